// ---- logic/eeprom_consts.svh ----
// constants for the serial eeprom slave write path
`ifndef EEPROM_CONSTS_SVH
`define EEPROM_CONSTS_SVH
// device-type code in the control byte; value is arbitrary here
`define DEV_CODE 4'h5
`define CLK_PERIOD_NS 8
`define WR_TIME_NS 5000000
`define WR_CYCLES (`WR_TIME_NS / `CLK_PERIOD_NS)
`define PAGE_BYTES 32
`define BITS_PER_BYTE 4'h8
`define ACK_BIT 4'h9
`define RW_BIT 0
`define CODE_HI 7
`define CODE_LO 4
`define CS_HI 3
`define CS_LO 1
`define ADDR_HI_BITS 4:0
`endif

// ---- logic/eeprom_pkg.sv ----
// types for the serial eeprom slave write path
`default_nettype none
package eeprom_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_CTRL, ST_ADDR_HI, ST_ADDR_LO, ST_DATA, ST_READ, ST_IGNORE
  } link_state_e;
endpackage
`default_nettype wire

// ---- logic/serial_eeprom_slave.sv ----
// two-wire eeprom slave: framing, addressing, page buffer and timed write
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_consts.svh"
// Behaviour
// (RULE1) master makes clock, starts and stops; device only ever acts as slave
// (RULE2) idle bus has both lines high; transfers begin only from idle
// (RULE3) data falling while clock high is Start; every command begins with it
// (RULE4) data rising while clock high is Stop; every operation ends with it
// (RULE5) one clock pulse per bit; data changes only while clock is low
// (RULE6) receiver holds data low through high phase of ninth acknowledge clock
// (RULE7) no acknowledge at all while an internal write cycle runs
// (RULE8) master withholds ack on last read byte; device releases data line
// (RULE9) control byte: device code plus chip-select bits must match strap pins
// (RULE10) control byte low bit: 1 selects read, 0 selects write
// (RULE11) two address bytes, high first; only 13 low bits form the address
// (RULE12) byte write acks control, both address bytes and data, then Stop
// (RULE13) Stop after write data launches timed write; device stays silent
// (RULE14) after a write the address counter points one past last written byte
// (RULE15) up to 31 more bytes buffered; committed only when Stop arrives
// (RULE16) only low five pointer bits increment; excess bytes overwrite in order
// (RULE17) master keeps page writes inside one aligned page
// (RULE18) write-protect high: ack write but skip cycle, store nothing, stay ready
// (RULE19) write-protect high guards whole array; low leaves writing enabled
// (RULE20) write-protect sampled at Stop; later changes ignored
// (RULE21) internal write cycle completes within 5 ms of its Stop
// (RULE22) master polls with Start plus write control byte until acked
// (RULE23) data line is only pulled low or released, as open drain
// (RULE24) write cycle length is a programmable count clearing busy on expiry
module serial_eeprom_slave #(
  parameter int WRITE_CYCLES = `WR_CYCLES,
  parameter int ADDR_W = 13,
  parameter int PAGE = `PAGE_BYTES
) (
  // system
  input wire logic clk_sys,
  input wire logic sys_rst,
  // link clock and data pin
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // strap pins
  input wire logic chip_sel_bit0,
  input wire logic chip_sel_bit1,
  input wire logic chip_sel_bit2,
  input wire logic write_protect,
  // status and array inspection
  output logic write_busy,
  output logic [ADDR_W-1:0] word_address_bits,
  input wire logic [ADDR_W-1:0] peek_addr,
  output logic [7:0] peek_data
);
  localparam int PW = $clog2(PAGE);
  localparam int DEPTH = 1 << ADDR_W;

  // link-domain sample: data is stable while the clock is high, so the
  // captured bit stays put long enough for the system side to take it
  logic scl_bit_q;
  always_ff @(posedge scl_clk) begin
    scl_bit_q <= sda_in; // (RULE5)
  end

  // pin synchronisers
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  logic [2:0] cs_s1_q, cs_s2_q;
  logic wp_s1_q, wp_s2_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7; // (RULE2)
      {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
      cs_s1_q <= 3'h0;
      cs_s2_q <= 3'h0;
      wp_s1_q <= 1'b0;
      wp_s2_q <= 1'b0;
    end else begin
      scl_s1_q <= scl_clk;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      cs_s1_q <= {chip_sel_bit2, chip_sel_bit1, chip_sel_bit0};
      cs_s2_q <= cs_s1_q;
      wp_s1_q <= write_protect;
      wp_s2_q <= wp_s1_q;
    end
  end

  logic rise_ev, fall_ev, start_ev, stop_ev;
  assign rise_ev = scl_s2_q && !scl_s3_q;
  assign fall_ev = !scl_s2_q && scl_s3_q;
  assign start_ev = scl_s2_q && scl_s3_q && !sda_s2_q && sda_s3_q; // (RULE3)
  assign stop_ev = scl_s2_q && scl_s3_q && sda_s2_q && !sda_s3_q; // (RULE4)

  eeprom_pkg::link_state_e state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic sda_oe_q;
  logic busy_q;
  logic [ADDR_W-1:0] addr_q;
  logic [PAGE-1:0] fill_q;
  logic [7:0] page_buf_q [PAGE];
  logic [7:0] mem_q [DEPTH];
  logic [31:0] wr_cnt_q;
  logic [ADDR_W-PW-1:0] page_base_q;
  logic [PAGE-1:0] commit_fill_q;
  logic byte_done, ctrl_match, data_take, commit_go;

  assign byte_done = fall_ev && bit_cnt_q == `BITS_PER_BYTE;
  assign ctrl_match = shift_q[`CODE_HI:`CODE_LO] == `DEV_CODE
                      && shift_q[`CS_HI:`CS_LO] == cs_s2_q && !busy_q; // (RULE9) (RULE7)
  assign data_take = byte_done && state_q == eeprom_pkg::ST_DATA;
  // wp low enables writing; high guards the whole array
  assign commit_go = stop_ev && state_q == eeprom_pkg::ST_DATA
                     && |fill_q && !wp_s2_q; // (RULE13) (RULE19) (RULE20)

  // bit counter and shifter: eight data bits then the acknowledge slot
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
    end else if (start_ev || stop_ev) begin
      bit_cnt_q <= 4'h0;
    end else if (rise_ev) begin
      if (bit_cnt_q < `BITS_PER_BYTE) begin
        shift_q <= {shift_q[6:0], scl_bit_q}; // (RULE5)
      end
      if (bit_cnt_q < `ACK_BIT) begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
    end else if (fall_ev && bit_cnt_q == `ACK_BIT) begin
      bit_cnt_q <= 4'h0;
    end
  end

  // protocol state
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= eeprom_pkg::ST_IDLE;
    end else if (start_ev) begin
      state_q <= eeprom_pkg::ST_CTRL; // (RULE3)
    end else if (stop_ev) begin
      state_q <= eeprom_pkg::ST_IDLE; // (RULE4)
    end else if (byte_done) begin
      unique case (state_q)
        eeprom_pkg::ST_CTRL: begin
          if (!ctrl_match) begin
            state_q <= eeprom_pkg::ST_IGNORE;
          end else if (shift_q[`RW_BIT]) begin
            state_q <= eeprom_pkg::ST_READ; // (RULE10)
          end else begin
            state_q <= eeprom_pkg::ST_ADDR_HI; // (RULE10)
          end
        end
        eeprom_pkg::ST_ADDR_HI: state_q <= eeprom_pkg::ST_ADDR_LO; // (RULE11)
        eeprom_pkg::ST_ADDR_LO: state_q <= eeprom_pkg::ST_DATA; // (RULE11)
        eeprom_pkg::ST_READ: state_q <= eeprom_pkg::ST_IGNORE;
        eeprom_pkg::ST_IDLE, eeprom_pkg::ST_DATA, eeprom_pkg::ST_IGNORE: state_q <= state_q;
      endcase
    end
  end

  // acknowledge drive: pulled low from the fall after bit 8 to the fall
  // after bit 9, so it is steady over the whole ninth high phase
  always_ff @(posedge clk_sys) begin
    if (sys_rst || start_ev || stop_ev) begin
      sda_oe_q <= 1'b0;
    end else if (byte_done) begin
      unique case (state_q)
        eeprom_pkg::ST_CTRL: sda_oe_q <= ctrl_match; // (RULE6) (RULE9) (RULE22)
        eeprom_pkg::ST_ADDR_HI, eeprom_pkg::ST_ADDR_LO,
        eeprom_pkg::ST_DATA: sda_oe_q <= 1'b1; // (RULE12) (RULE18)
        eeprom_pkg::ST_IDLE, eeprom_pkg::ST_READ,
        eeprom_pkg::ST_IGNORE: sda_oe_q <= 1'b0; // (RULE8)
      endcase
    end else if (fall_ev && bit_cnt_q == `ACK_BIT) begin
      sda_oe_q <= 1'b0; // (RULE6) (RULE23)
    end
  end

  // address pointer: high bits kept, only page offset advances per byte
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      addr_q <= '0;
    end else if (byte_done && state_q == eeprom_pkg::ST_ADDR_HI) begin
      addr_q[ADDR_W-1:8] <= shift_q[`ADDR_HI_BITS]; // (RULE11)
    end else if (byte_done && state_q == eeprom_pkg::ST_ADDR_LO) begin
      addr_q[7:0] <= shift_q; // (RULE11)
    end else if (data_take) begin
      addr_q[PW-1:0] <= addr_q[PW-1:0] + PW'(1); // (RULE14) (RULE16) (RULE17)
    end
  end

  // page buffer; a later byte at the same offset replaces the earlier one
  always_ff @(posedge clk_sys) begin
    if (sys_rst || start_ev) begin
      fill_q <= '0;
    end else if (data_take) begin
      fill_q[addr_q[PW-1:0]] <= 1'b1; // (RULE15)
    end
  end
  always_ff @(posedge clk_sys) begin
    if (data_take) begin
      page_buf_q[addr_q[PW-1:0]] <= shift_q; // (RULE15) (RULE16)
    end
  end

  // timed write cycle; commit copies one buffer slot per cycle, so the
  // count must be at least the page size
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      wr_cnt_q <= 32'h0;
      page_base_q <= '0;
      commit_fill_q <= '0;
    end else if (commit_go && !busy_q) begin
      busy_q <= 1'b1; // (RULE13)
      wr_cnt_q <= 32'h0;
      page_base_q <= addr_q[ADDR_W-1:PW];
      commit_fill_q <= fill_q; // (RULE15)
    end else if (busy_q) begin
      if (wr_cnt_q == 32'(WRITE_CYCLES - 1)) begin
        busy_q <= 1'b0; // (RULE21) (RULE24)
      end
      wr_cnt_q <= wr_cnt_q + 32'h1; // (RULE24)
    end
  end
  always_ff @(posedge clk_sys) begin
    if (busy_q && wr_cnt_q < 32'(PAGE) && commit_fill_q[wr_cnt_q[PW-1:0]]) begin
      mem_q[{page_base_q, wr_cnt_q[PW-1:0]}] <= page_buf_q[wr_cnt_q[PW-1:0]]; // (RULE15)
    end
  end

  // outputs, all registered
  logic sda_out_q;
  logic [7:0] peek_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sda_out_q <= 1'b0;
      peek_q <= 8'h00;
    end else begin
      sda_out_q <= 1'b0; // (RULE23)
      peek_q <= mem_q[peek_addr];
    end
  end
  assign sda_out = sda_out_q;
  assign sda_oe = sda_oe_q;
  assign write_busy = busy_q;
  assign word_address_bits = addr_q;
  assign peek_data = peek_q;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_write_stop;
    stop_ev && state_q == eeprom_pkg::ST_DATA && |fill_q && !busy_q;
  endsequence
  sequence s_busy_window;
    busy_q [*8];
  endsequence

  a_busy_no_ack: assert property (busy_q |-> !sda_oe_q) // (RULE7)
    else $error("acknowledge driven during write cycle");
  a_ack_while_low: assert property ($rose(sda_oe_q) |-> !scl_s2_q) // (RULE5)
    else $error("data line pulled while clock high");
  a_ack_slot: assert property ($rose(sda_oe_q) |-> bit_cnt_q == 4'h8
    ##1 (sda_oe_q && !start_ev && !stop_ev) [*8]) // (RULE6)
    else $error("acknowledge not held into ninth clock");
  a_commit_busy: assert property (s_write_stop ##0 !wp_s2_q |=> s_busy_window) // (RULE13)
    else $error("write cycle not launched on stop");
  a_protect_skip: assert property (s_write_stop ##0 wp_s2_q |=> !busy_q [*3]) // (RULE18)
    else $error("protected write started a cycle");
  a_cycle_bound: assert property (busy_q |-> wr_cnt_q < 32'(WRITE_CYCLES)) // (RULE21)
    else $error("write cycle overran its count");
  a_ptr_wrap: assert property (data_take |=> addr_q[ADDR_W-1:PW] == $past(addr_q[ADDR_W-1:PW])
    && addr_q[PW-1:0] == $past(addr_q[PW-1:0]) + PW'(1)) // (RULE16)
    else $error("pointer did not wrap within page");
  a_ctrl_match: assert property (byte_done && state_q == eeprom_pkg::ST_CTRL && !ctrl_match
    |=> !sda_oe_q) // (RULE9)
    else $error("acknowledge without matching control byte");
  a_start_ctrl: assert property (start_ev |=> state_q == eeprom_pkg::ST_CTRL
    && bit_cnt_q == 4'h0) // (RULE3)
    else $error("start did not open a control byte");
  a_stop_idle: assert property (stop_ev |=> state_q == eeprom_pkg::ST_IDLE && !sda_oe_q) // (RULE4)
    else $error("stop did not end the operation");
endmodule // serial_eeprom_slave
`default_nettype wire

// ---- verification/bus_master.sv ----
// bus master model: drives the serial clock and pulls the data wire low
`timescale 1ns/100ps
`default_nettype none
module bus_master (
  // wire side
  output logic scl,
  output logic sda_low,
  input wire logic sda_line
);
  localparam realtime Q = 31.25;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // works from idle and as a repeated start from clock low
  task automatic start();
    #Q sda_low = 1'b0;
    #Q scl = 1'b1;
    #(2*Q) sda_low = 1'b1;
    #(2*Q) scl = 1'b0;
  endtask
  // clock then stands still high outside frames
  task automatic stop();
    #Q sda_low = 1'b1;
    #Q scl = 1'b1;
    #(2*Q) sda_low = 1'b0;
    #(2*Q);
  endtask
  task automatic bit_io(input logic b, output logic r);
    #Q sda_low = ~b;
    #Q scl = 1'b1;
    #Q r = sda_line;
    #Q scl = 1'b0;
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
endmodule // bus_master
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for the serial eeprom slave write path
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_consts.svh"
module testbench;
  localparam int WC = 256;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] cs = 3'h5;
  logic write_protect = 1'b0;
  logic [12:0] peek_addr = 13'h0;
  logic scl_clk, m_low, sda_oe, sda_out, write_busy;
  logic [12:0] word_address_bits;
  logic [7:0] peek_data;
  wire logic sda_line;
  int err_count = 0;
  int num_checks = 0;
  int busy_cnt = 0;
  int cycles = 0;
  // open-drain wire with pull-up: low when either party pulls
  assign sda_line = ~(m_low | (sda_oe & ~sda_out));
  always #4 clk_sys = ~clk_sys;
  always @(negedge clk_sys) if (write_busy === 1'b1) busy_cnt++;
  bus_master u_bus_master (.scl(scl_clk), .sda_low(m_low), .sda_line(sda_line));
  serial_eeprom_slave #(.WRITE_CYCLES(WC)) u_serial_eeprom_slave (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .scl_clk(scl_clk), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .chip_sel_bit0(cs[0]), .chip_sel_bit1(cs[1]),
    .chip_sel_bit2(cs[2]), .write_protect(write_protect), .write_busy(write_busy),
    .word_address_bits(word_address_bits), .peek_addr(peek_addr), .peek_data(peek_data));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tx(input logic [7:0] b, input logic exp_ack);
    logic a;
    u_bus_master.send(b, a);
    check(a, exp_ack);
  endtask
  // write: control, address high then low, n data bytes from base, stop
  task automatic write_seq(input logic [15:0] a, input int n, input logic [7:0] base);
    busy_cnt = 0;
    u_bus_master.start();
    tx({`DEV_CODE, cs, 1'b0}, 1'b1);
    tx(a[15:8], 1'b1);
    tx(a[7:0], 1'b1);
    for (int i = 0; i < n; i++) tx(base + 8'(i), 1'b1);
    u_bus_master.stop();
  endtask
  // bounded wait for the write cycle to finish
  task automatic wait_idle();
    for (int i = 0; i < 2000 && write_busy !== 1'b0; i++) @(negedge clk_sys);
    check(write_busy, 1'b0);
  endtask
  task automatic peek(input logic [12:0] a, input logic [7:0] exp);
    @(negedge clk_sys) peek_addr = a;
    repeat (2) @(negedge clk_sys);
    check(peek_data, exp);
  endtask
  task automatic byte_write();
    write_seq(16'hfabc, 1, 8'h3c);
    @(negedge clk_sys) write_protect = 1'b1;
    u_bus_master.start();
    tx({`DEV_CODE, cs, 1'b0}, 1'b0);
    u_bus_master.stop();
    wait_idle();
    check(16'(busy_cnt), 16'(WC));
    @(negedge clk_sys) write_protect = 1'b0;
    peek(13'h1abc, 8'h3c);
    check(word_address_bits, 13'h1abd);
  endtask
  // 33 bytes from page offset 30 wrap and overwrite the first one
  task automatic page_write();
    int k;
    write_seq(16'h0b5e, 33, 8'h40);
    wait_idle();
    check(16'(busy_cnt), 16'(WC));
    check(word_address_bits, 13'h0b5f);
    for (int off = 0; off < 32; off++) begin
      k = (off + 2) & 31;
      if (k == 0) k = 32;
      peek(13'h0b40 + 13'(off), 8'h40 + 8'(k));
    end
  endtask
  task automatic protected_write();
    @(negedge clk_sys) write_protect = 1'b1;
    write_seq(16'h1abc, 2, 8'h99);
    repeat (40) @(negedge clk_sys);
    check(16'(busy_cnt), 16'h0000);
    peek(13'h1abc, 8'h3c);
    u_bus_master.start();
    tx({`DEV_CODE, cs, 1'b0}, 1'b1);
    u_bus_master.stop();
    @(negedge clk_sys) write_protect = 1'b0;
  endtask
  // every strap setting: matching select acked, complemented select and bad code ignored
  task automatic addressing();
    for (int k = 0; k < 8; k++) begin
      @(negedge clk_sys) cs = 3'(k);
      repeat (4) @(negedge clk_sys);
      u_bus_master.start();
      tx({`DEV_CODE, 3'(k), 1'b0}, 1'b1);
      u_bus_master.start();
      tx({`DEV_CODE, 3'(k) ^ 3'h7, 1'b0}, 1'b0);
      u_bus_master.start();
      tx({`DEV_CODE ^ 4'h1, 3'(k), 1'b0}, 1'b0);
      u_bus_master.start();
      tx({`DEV_CODE, 3'(k), 1'b1}, 1'b1);
      u_bus_master.stop();
    end
    @(negedge clk_sys) cs = 3'h5;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    repeat (20) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (6) @(negedge clk_sys);
    check(write_busy, 1'b0);
    check(sda_oe, 1'b0);
    check(sda_out, 1'b0);
    byte_write();
    page_write();
    protected_write();
    addressing();
    summarize();
  end
endmodule // testbench
`default_nettype wire
